// ===== rtl/regseq_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef REGSEQ_DEFINES_SVH
`define REGSEQ_DEFINES_SVH
`define OFS_RAIL1_DELAY   8'h13
`define OFS_RAIL2_DELAY   8'h14
`define OFS_RAIL3_DELAY   8'h15
`define OFS_SOFT_RESET    8'h16
`define OFS_DEV_CONFIG    8'h17
`define OFS_TOP_INT       8'h18
`define OFS_RAIL01_CAUSE  8'h19
`define OFS_RAIL23_CAUSE  8'h1A
`define RST_DELAY         8'h00
`define RST_CONFIG        8'h06
`define CFG_WARN_SEL_BIT  3
`define CFG_PD2_BIT       2
`define CFG_PD1_BIT       1
`define CFG_SPREAD_BIT    0
`define TOP_TSD_BIT       3
`define TOP_TWARN_BIT     2
`define TOP_RESET_BIT     1
`define TOP_ILOAD_BIT     0
`define CLK_FREQ_HZ       25000000
`define TICK_PERIOD_MS    1
`define TICK_CYCLES       ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
`define CAUSE_MASK        8'h77
`endif

// ===== rtl/regseq_pkg.sv
// types shared by the sequencer register block
package regseq_pkg;
    typedef enum logic [1:0] {
        RAIL_OFF     = 2'b00,
        RAIL_WAKE    = 2'b01,
        RAIL_ON      = 2'b10,
        RAIL_SLEEP   = 2'b11
    } rail_state_t;
endpackage

// ===== rtl/rail_delay_seq.sv
// one rail's start-up / shutdown delay sequencer
`timescale 1ns/10ps
module rail_delay_seq
    import regseq_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       power_on_reset_pin_i,
    input  wire logic       ce_i,
    input  wire logic       clr_i,
    input  wire logic       tick_i,
    input  wire logic       enable_i,
    input  wire logic       block_i,
    input  wire logic [3:0] on_delay_i,
    input  wire logic [3:0] off_delay_i,
    output logic            rail_on_o
);
    rail_state_t state_r;
    rail_state_t state_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            RAIL_OFF: begin
                if (enable_i && !block_i) begin
                    state_nxt = (on_delay_i == 4'h0) ? RAIL_ON : RAIL_WAKE;
                    cnt_nxt   = on_delay_i;
                end
            end
            RAIL_WAKE: begin
                if (!enable_i || block_i) begin
                    state_nxt = RAIL_OFF;
                end else if (tick_i) begin
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_nxt = RAIL_ON;
                    end
                end
            end
            RAIL_ON: begin
                if (block_i) begin
                    state_nxt = RAIL_OFF;
                end else if (!enable_i) begin
                    state_nxt = (off_delay_i == 4'h0) ? RAIL_OFF : RAIL_SLEEP;
                    cnt_nxt   = off_delay_i;
                end
            end
            RAIL_SLEEP: begin
                if (block_i) begin
                    state_nxt = RAIL_OFF;
                end else if (enable_i) begin
                    state_nxt = RAIL_ON;
                end else if (tick_i) begin
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_nxt = RAIL_OFF;
                    end
                end
            end
            default: state_nxt = RAIL_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            state_r <= RAIL_OFF;
            cnt_r   <= 4'h0;
        end else if (ce_i) begin
            state_r <= clr_i ? RAIL_OFF : state_nxt;
            cnt_r   <= clr_i ? 4'h0 : cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            rail_on_o <= 1'b0;
        end else if (ce_i) begin
            rail_on_o <= !clr_i && (state_nxt == RAIL_ON || state_nxt == RAIL_SLEEP);
        end
    end

    chk_block_forces_off: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && block_i) |=> !rail_on_o)
        else $error("rail stayed on while blocked");
    chk_zero_on_delay: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && !clr_i && state_r == RAIL_OFF && enable_i && !block_i
         && on_delay_i == 4'h0) |=> rail_on_o)
        else $error("zero start delay not immediate");
endmodule

// ===== rtl/regseq_top.sv
// sequencing delay, reset, configuration and top interrupt registers
`timescale 1ns/10ps
`include "regseq_defines.svh"
module regseq_top
    import regseq_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       power_on_reset_pin_i,
    input  wire logic       ce_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    input  wire logic       enable_inputs_i,
    input  wire logic       tsd_level_i,
    input  wire logic       twarn_hot_i,
    input  wire logic       twarn_cool_i,
    input  wire logic       analog_supply_low_i,
    input  wire logic       iload_ready_i,
    input  wire logic [7:0] cause_set_i,
    output logic      [2:0] rail_on_o,
    output logic            thermal_warn_threshold_sel_o,
    output logic            second_enable_pulldown_o,
    output logic            first_enable_pulldown_o,
    output logic            spread_spectrum_on_o,
    output logic            serial_reset_o,
    output logic            otp_reload_o,
    output logic            warn_status_o,
    output logic            irq_o
);
    // pin-level inputs go through three flops
    logic [2:0] en_sy_r;
    logic [2:0] tsd_sy_r;
    logic [2:0] tw_hot_sy_r;
    logic [2:0] tw_cool_sy_r;
    logic [2:0] uv_sy_r;
    logic       en_q_r;
    logic       tsd_q_r;
    logic       warn_q_r;
    logic       uv_q_r;

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            en_sy_r      <= 3'h0;
            tsd_sy_r     <= 3'h0;
            tw_hot_sy_r  <= 3'h0;
            tw_cool_sy_r <= 3'h0;
            uv_sy_r      <= 3'h0;
        end else if (ce_i) begin
            en_sy_r      <= {en_sy_r[1:0], enable_inputs_i};
            tsd_sy_r     <= {tsd_sy_r[1:0], tsd_level_i};
            tw_hot_sy_r  <= {tw_hot_sy_r[1:0], twarn_hot_i};
            tw_cool_sy_r <= {tw_cool_sy_r[1:0], twarn_cool_i};
            uv_sy_r      <= {uv_sy_r[1:0], analog_supply_low_i};
        end
    end

    wire en_agree    = en_sy_r[1] == en_sy_r[2];
    wire tsd_agree   = tsd_sy_r[1] == tsd_sy_r[2];
    wire uv_agree    = uv_sy_r[1] == uv_sy_r[2];
    wire hot_agree   = tw_hot_sy_r[1] == tw_hot_sy_r[2];
    wire cool_agree  = tw_cool_sy_r[1] == tw_cool_sy_r[2];

    // registers
    logic [7:0] rail_delay_r [3];
    logic [7:0] config_r;
    logic [3:0] top_evt_r;
    logic [7:0] cause01_r;
    logic [7:0] cause23_r;
    logic       soft_rst_r;
    logic       por_seen_r;

    wire wr_rail1   = wr_en_i && addr_i == `OFS_RAIL1_DELAY;
    wire wr_rail2   = wr_en_i && addr_i == `OFS_RAIL2_DELAY;
    wire wr_rail3   = wr_en_i && addr_i == `OFS_RAIL3_DELAY;
    wire wr_soft    = wr_en_i && addr_i == `OFS_SOFT_RESET;
    wire wr_config  = wr_en_i && addr_i == `OFS_DEV_CONFIG;
    wire wr_top     = wr_en_i && addr_i == `OFS_TOP_INT;
    wire wr_c01     = wr_en_i && addr_i == `OFS_RAIL01_CAUSE;
    wire wr_c23     = wr_en_i && addr_i == `OFS_RAIL23_CAUSE;

    wire soft_req   = wr_soft && wdata_i[0];
    wire uv_rise    = uv_agree && uv_sy_r[2] && !uv_q_r;
    // any reset event restores defaults (soft request acts one cycle later)
    wire reg_clear  = soft_rst_r || uv_rise;

    wire warn_sel   = config_r[`CFG_WARN_SEL_BIT];
    wire warn_lvl   = warn_sel ? tw_cool_sy_r[2] : tw_hot_sy_r[2];
    wire warn_ok    = warn_sel ? cool_agree : hot_agree;
    wire warn_live  = warn_ok ? warn_lvl : warn_q_r;
    wire tsd_live   = tsd_agree ? tsd_sy_r[2] : tsd_q_r;
    wire en_live    = en_agree ? en_sy_r[2] : en_q_r;

    wire tsd_rise   = tsd_live && !tsd_q_r;
    wire warn_rise  = warn_live && !warn_q_r;
    wire reset_evt  = soft_rst_r || uv_rise || !por_seen_r;

    // set wins over a write-one clear
    wire [3:0] evt_set = {tsd_rise, warn_rise, reset_evt, iload_ready_i};
    wire [3:0] evt_clr = wr_top ? wdata_i[3:0] : 4'h0;
    wire [3:0] top_evt_nxt = evt_set | (top_evt_r & ~evt_clr);

    // cause_set_i[4+n] selects rail n, cause_set_i[2:0] are the flags to set
    wire [2:0] cause_flags = cause_set_i[2:0];
    wire [7:0] c01_set = {1'b0, cause_set_i[5] ? cause_flags : 3'h0,
                          1'b0, cause_set_i[4] ? cause_flags : 3'h0};
    wire [7:0] c23_set = {1'b0, cause_set_i[7] ? cause_flags : 3'h0,
                          1'b0, cause_set_i[6] ? cause_flags : 3'h0};
    wire [7:0] c01_nxt = c01_set | (cause01_r & ~(wr_c01 ? wdata_i : 8'h00));
    wire [7:0] c23_nxt = c23_set | (cause23_r & ~(wr_c23 ? wdata_i : 8'h00));

    wire [3:0] summary = {cause23_r[6:4] != 3'h0, cause23_r[2:0] != 3'h0,
                          cause01_r[6:4] != 3'h0, cause01_r[2:0] != 3'h0};
    wire [7:0] top_view = {summary, top_evt_r};

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            en_q_r     <= 1'b0;
            tsd_q_r    <= 1'b0;
            warn_q_r   <= 1'b0;
            uv_q_r     <= 1'b0;
            por_seen_r <= 1'b0;
        end else if (ce_i) begin
            en_q_r     <= en_live;
            tsd_q_r    <= tsd_live;
            warn_q_r   <= warn_live;
            uv_q_r     <= uv_agree ? uv_sy_r[2] : uv_q_r;
            por_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            soft_rst_r <= 1'b0;
        end else if (ce_i) begin
            soft_rst_r <= soft_req && !soft_rst_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            rail_delay_r[0] <= `RST_DELAY;
            rail_delay_r[1] <= `RST_DELAY;
            rail_delay_r[2] <= `RST_DELAY;
            config_r        <= `RST_CONFIG;
        end else if (ce_i) begin
            if (reg_clear) begin
                rail_delay_r[0] <= `RST_DELAY;
                rail_delay_r[1] <= `RST_DELAY;
                rail_delay_r[2] <= `RST_DELAY;
                config_r        <= `RST_CONFIG;
            end else begin
                if (wr_rail1) rail_delay_r[0] <= wdata_i;
                if (wr_rail2) rail_delay_r[1] <= wdata_i;
                if (wr_rail3) rail_delay_r[2] <= wdata_i;
                if (wr_config) config_r <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            top_evt_r <= 4'h0;
            cause01_r <= 8'h00;
            cause23_r <= 8'h00;
        end else if (ce_i) begin
            top_evt_r <= top_evt_nxt;
            cause01_r <= reg_clear ? 8'h00 : (c01_nxt & `CAUSE_MASK);
            cause23_r <= reg_clear ? 8'h00 : (c23_nxt & `CAUSE_MASK);
        end
    end

    // millisecond tick shared by all rails
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
    wire tick = tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            tick_cnt_r <= '0;
        end else if (ce_i) begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // converters stay off while the shutdown latch or a reset is active
    wire rail_block = top_evt_r[`TOP_TSD_BIT] || reg_clear;
    logic [2:0] rail_on_w;
    for (genvar g = 0; g < 3; g++) begin : g_rail
        rail_delay_seq u_seq (
            .clk_sys_i   (clk_sys_i),
            .power_on_reset_pin_i      (power_on_reset_pin_i),
            .ce_i        (ce_i),
            .clr_i       (reg_clear),
            .tick_i      (tick),
            .enable_i    (en_live),
            .block_i     (rail_block),
            .on_delay_i  (rail_delay_r[g][3:0]),
            .off_delay_i (rail_delay_r[g][7:4]),
            .rail_on_o   (rail_on_w[g])
        );
    end

    logic [7:0] rdata_nxt;
    always_comb begin
        case (addr_i)
            `OFS_RAIL1_DELAY:  rdata_nxt = rail_delay_r[0];
            `OFS_RAIL2_DELAY:  rdata_nxt = rail_delay_r[1];
            `OFS_RAIL3_DELAY:  rdata_nxt = rail_delay_r[2];
            `OFS_SOFT_RESET:   rdata_nxt = 8'h00;
            `OFS_DEV_CONFIG:   rdata_nxt = config_r;
            `OFS_TOP_INT:      rdata_nxt = top_view;
            `OFS_RAIL01_CAUSE: rdata_nxt = cause01_r;
            `OFS_RAIL23_CAUSE: rdata_nxt = cause23_r;
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge power_on_reset_pin_i) begin
        if (!power_on_reset_pin_i) begin
            rdata_o                      <= 8'h00;
            rail_on_o                    <= 3'h0;
            thermal_warn_threshold_sel_o <= 1'b0;
            second_enable_pulldown_o     <= 1'b1;
            first_enable_pulldown_o      <= 1'b1;
            spread_spectrum_on_o         <= 1'b0;
            serial_reset_o               <= 1'b0;
            otp_reload_o                 <= 1'b0;
            warn_status_o                <= 1'b0;
            irq_o                        <= 1'b0;
        end else if (ce_i) begin
            rdata_o                      <= rdata_nxt;
            rail_on_o                    <= rail_on_w;
            thermal_warn_threshold_sel_o <= config_r[`CFG_WARN_SEL_BIT];
            second_enable_pulldown_o     <= config_r[`CFG_PD2_BIT];
            first_enable_pulldown_o      <= config_r[`CFG_PD1_BIT];
            spread_spectrum_on_o         <= config_r[`CFG_SPREAD_BIT];
            serial_reset_o               <= soft_rst_r;
            otp_reload_o                 <= reset_evt;
            warn_status_o                <= warn_live;
            irq_o                        <= top_view != 8'h00;
        end
    end

    chk_soft_self_clear: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && soft_req && !soft_rst_r) |=> (soft_rst_r ##1 (!ce_i || !soft_rst_r)))
        else $error("soft reset request did not clear itself");
    chk_soft_restores: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && soft_rst_r) |=> (config_r == `RST_CONFIG && rail_delay_r[0] == 8'h00))
        else $error("soft reset left registers dirty");
    chk_otp_on_soft: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && soft_rst_r) |=> otp_reload_o)
        else $error("soft reset did not reload settings");
    chk_event_w1c: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && wr_top && wdata_i[0] && !iload_ready_i) |=> !top_evt_r[0])
        else $error("write one did not clear load event");
    chk_event_w0_keep: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && top_evt_r[2] && !(wr_top && wdata_i[2])) |=> top_evt_r[2])
        else $error("warning latch lost without clear");
    chk_load_latch: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && iload_ready_i) |=> top_evt_r[0])
        else $error("load ready not latched");
    chk_tsd_latch: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && tsd_rise) |=> top_evt_r[3] ##2 (!ce_i || rail_on_o == 3'h0))
        else $error("thermal shutdown not latched or rails left on");
    chk_summary_clear: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && wr_c01 && (cause01_r[2:0] & ~wdata_i[2:0]) == 3'h0
         && !(cause_set_i[4] && cause_set_i[2:0] != 3'h0)) |=> !top_view[4])
        else $error("summary kept after cause cleared");
    chk_rail2_summary: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && !reg_clear && cause_set_i[6] && cause_set_i[2:0] != 3'h0) |=> top_view[6])
        else $error("rail 2 cause did not raise its summary");
    chk_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && top_view != 8'h00) |=> irq_o)
        else $error("interrupt output missed pending bit");
    chk_warn_latch: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && warn_rise) |=> top_evt_r[2])
        else $error("warning crossing not latched");
    chk_cfg_out: assert property (@(posedge clk_sys_i) disable iff (!power_on_reset_pin_i)
        (ce_i && !reg_clear && wr_config) |=> ##1 (!ce_i ||
         first_enable_pulldown_o == $past(wdata_i[1], 2)))
        else $error("pulldown output does not follow config");
endmodule

// ===== tb/host_model.sv
// host side of the register port: one write strobe or one read per call
`timescale 1ns/10ps
module host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end
    // strobe held over exactly one taking edge, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        wr_en_o = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(posedge clk_sys_i);
        #1;
        wr_en_o = 1'b0;
        wdata_o = ~d;
    endtask
    // address held until the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        addr_o = a;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        d = rdata_i;
    endtask
endmodule

// ===== tb/regulator_seq_config_irq_regs_bench.sv
// self-checking bench for the sequencing and top interrupt register block
`timescale 1ns/10ps
module regulator_seq_config_irq_regs_bench;
    localparam int TICK = 10;
    logic       clk_sys_i = 1'b0;
    logic       power_on_reset_pin = 1'b0;
    logic       enable_inputs = 1'b0;
    logic       tsd_level = 1'b0;
    logic       twarn_hot = 1'b0;
    logic       twarn_cool = 1'b0;
    logic       analog_low = 1'b0;
    logic       iload_ready = 1'b0;
    logic [7:0] cause_set = 8'h00;
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] rail_on;
    logic [7:0] cfg_out;
    logic       sel_o, pd2_o, pd1_o, ss_o, ser_rst, otp, warn_st, irq;
    logic       ser_seen = 1'b0;
    logic       otp_seen = 1'b0;
    logic       ce = 1'b1;
    int         bad_count = 0;
    int         num_checks = 0;
    logic [7:0] dly [3] = '{8'h12, 8'h30, 8'hF5};

    assign cfg_out = {4'h0, sel_o, pd2_o, pd1_o, ss_o};
    always #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (ser_rst === 1'b1) ser_seen <= 1'b1;
        if (otp === 1'b1) otp_seen <= 1'b1;
    end

    regseq_top #(.TICK_CYCLES(TICK)) regseq_top_i (
        .clk_sys_i(clk_sys_i), .power_on_reset_pin_i(power_on_reset_pin), .ce_i(ce), .wr_en_i(wr_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .enable_inputs_i(enable_inputs), .tsd_level_i(tsd_level),
        .twarn_hot_i(twarn_hot), .twarn_cool_i(twarn_cool),
        .analog_supply_low_i(analog_low), .iload_ready_i(iload_ready),
        .cause_set_i(cause_set), .rail_on_o(rail_on),
        .thermal_warn_threshold_sel_o(sel_o), .second_enable_pulldown_o(pd2_o),
        .first_enable_pulldown_o(pd1_o), .spread_spectrum_on_o(ss_o),
        .serial_reset_o(ser_rst), .otp_reload_o(otp), .warn_status_o(warn_st),
        .irq_o(irq)
    );
    host_model host_model_i (
        .clk_sys_i(clk_sys_i), .rdata_i(rdata), .wr_en_o(wr_en),
        .addr_o(addr), .wdata_o(wdata)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_model_i.rd(a, d);
        check(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic pulse_in(input logic il, input logic [7:0] cs);
        iload_ready = il;
        cause_set = cs;
        cyc(1);
        iload_ready = 1'b0;
        cause_set = 8'h00;
    endtask
    // moves the enable pin and times each rail against its own nibble
    task automatic run_rails(input logic en);
        int t [3];
        int c;
        t = '{-1, -1, -1};
        enable_inputs = en;
        for (int k = 0; k < 220; k++) begin
            cyc(1);
            for (int r = 0; r < 3; r++)
                if (t[r] < 0 && rail_on[r] === en) t[r] = k;
        end
        for (int r = 0; r < 3; r++) begin
            c = en ? dly[r][3:0] : dly[r][7:4];
            check(8'(t[r] >= (c - 1) * TICK && t[r] <= c * TICK + 10), 8'h01);
        end
    endtask

    initial begin
        cyc(8);
        power_on_reset_pin = 1'b1;
        cyc(2);
        check(cfg_out, 8'h06);
        check({7'h00, otp_seen}, 8'h01);
        rchk(8'h18, 8'h02);
        check({7'h00, irq}, 8'h01);
        for (int a = 8'h13; a <= 8'h16; a++) rchk(8'(a), 8'h00);
        rchk(8'h17, 8'h06);
        rchk(8'h20, 8'h00);
        // a write while the clock enable is low must not land
        ce = 1'b0;
        host_model_i.wr(8'h13, 8'h5A);
        ce = 1'b1;
        rchk(8'h13, 8'h00);
        host_model_i.wr(8'h18, 8'hF0);
        rchk(8'h18, 8'h02);
        host_model_i.wr(8'h18, 8'h02);
        rchk(8'h18, 8'h00);
        check({7'h00, irq}, 8'h00);
        // lower warning level selected, other bits flipped from default
        host_model_i.wr(8'h17, 8'h09);
        rchk(8'h17, 8'h09);
        check(cfg_out, 8'h09);
        twarn_cool = 1'b1;
        cyc(8);
        check({7'h00, warn_st}, 8'h01);
        twarn_cool = 1'b0;
        rchk(8'h18, 8'h04);
        host_model_i.wr(8'h18, 8'h04);
        host_model_i.wr(8'h17, 8'h06);
        twarn_cool = 1'b1;
        cyc(8);
        rchk(8'h18, 8'h00);
        twarn_hot = 1'b1;
        cyc(8);
        rchk(8'h18, 8'h04);
        twarn_hot = 1'b0;
        twarn_cool = 1'b0;
        host_model_i.wr(8'h18, 8'h04);
        pulse_in(1'b1, 8'h00);
        rchk(8'h18, 8'h01);
        host_model_i.wr(8'h18, 8'h01);
        // rails 0 and 2 take flag 0, the unused select bit 3 is set too
        pulse_in(1'b0, 8'h59);
        rchk(8'h19, 8'h01);
        rchk(8'h1A, 8'h01);
        rchk(8'h18, 8'h50);
        host_model_i.wr(8'h18, 8'hF0);
        rchk(8'h18, 8'h50);
        host_model_i.wr(8'h19, 8'h01);
        rchk(8'h18, 8'h40);
        host_model_i.wr(8'h1A, 8'h01);
        rchk(8'h18, 8'h00);
        check({7'h00, irq}, 8'h00);
        // rails 1 and 3 take two flags each
        pulse_in(1'b0, 8'hA6);
        rchk(8'h19, 8'h60);
        rchk(8'h1A, 8'h60);
        rchk(8'h18, 8'hA0);
        host_model_i.wr(8'h19, 8'h20);
        rchk(8'h19, 8'h40);
        host_model_i.wr(8'h19, 8'h40);
        host_model_i.wr(8'h1A, 8'hFF);
        rchk(8'h18, 8'h00);
        check({7'h00, irq}, 8'h00);
        for (int r = 0; r < 3; r++) begin
            host_model_i.wr(8'(8'h13 + r), dly[r]);
            rchk(8'(8'h13 + r), dly[r]);
        end
        run_rails(1'b1);
        run_rails(1'b0);
        run_rails(1'b1);
        tsd_level = 1'b1;
        cyc(10);
        check({5'h00, rail_on}, 8'h00);
        tsd_level = 1'b0;
        cyc(80);
        check({5'h00, rail_on}, 8'h00);
        rchk(8'h18, 8'h08);
        host_model_i.wr(8'h18, 8'h08);
        cyc(80);
        check({5'h00, rail_on}, 8'h07);
        ser_seen = 1'b0;
        otp_seen = 1'b0;
        host_model_i.wr(8'h16, 8'h01);
        cyc(4);
        check({7'h00, ser_seen}, 8'h01);
        check({7'h00, otp_seen}, 8'h01);
        rchk(8'h16, 8'h00);
        rchk(8'h15, 8'h00);
        rchk(8'h17, 8'h06);
        rchk(8'h18, 8'h02);
        host_model_i.wr(8'h18, 8'h02);
        host_model_i.wr(8'h13, 8'h12);
        otp_seen = 1'b0;
        analog_low = 1'b1;
        cyc(8);
        analog_low = 1'b0;
        check({7'h00, otp_seen}, 8'h01);
        rchk(8'h13, 8'h00);
        rchk(8'h18, 8'h02);
        summarize();
    end

    initial begin
        cyc(20000);
        bad_count++;
        summarize();
    end
endmodule
